// ---- hdl/spfp_fuse_bank.sv ----
module spfp_fuse_bank
#(
	parameter int N = 4
)
(
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire logic              blow_i,
	input  wire logic [1:0]        reg_i,
	input  wire logic [9:0]        bit_i,
	input  wire logic [N*10-1:0]   fuse_init_i,
	output logic      [N*10-1:0]   fuse_o
);
	// ==========================================
	// fuse array model; fuses only ever go from 0 to 1
	typedef struct packed {
		logic [N*10-1:0] f;
		logic            init;
	} spfp_fb_t;

	spfp_fb_t s, next_s;

	// blown state is sampled once after reset, standing in for fuse sense
	always_comb
	begin
		next_s = s;
		if (!s.init)
		begin
			next_s.f = fuse_init_i;
			next_s.init = 1'b1;
		end
		else if (blow_i)
			next_s.f[reg_i*10 +: 10] = s.f[reg_i*10 +: 10] | bit_i;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign fuse_o = s.f;

	// no blown bit ever clears
	fuse_keep_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init |=> (s.f & $past(s.f)) == $past(s.f))
		else $error("blown fuse cleared");
endmodule // spfp_fuse_bank

// ---- hdl/spfp_level_det.sv ----
module spfp_level_det
(
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       above_mid_i,
	input  wire logic       above_high_i,
	spfp_pulse_if.src       ev
);
	// ==========================================
	// filtered level classifier
	typedef struct packed {
		spfp_pkg::spfp_lvl_t raw;
		spfp_pkg::spfp_lvl_t lvl;
		spfp_pkg::spfp_lvl_t peak;
		logic [7:0]          fcnt;
		logic [15:0]         hcnt;
		logic                mid_p;
		logic                high_p;
		logic                long_p;
	} spfp_det_t;

	spfp_det_t s, next_s;
	spfp_pkg::spfp_lvl_t cur;

	// comparators glitch out slowly on supply ramps, so a level must hold
	always_comb
	begin
		next_s = s;
		next_s.mid_p = 1'b0;
		next_s.high_p = 1'b0;
		next_s.long_p = 1'b0;
		if (above_high_i)
			cur = spfp_pkg::SPFP_LVL_HIGH;
		else if (above_mid_i)
			cur = spfp_pkg::SPFP_LVL_MID;
		else
			cur = spfp_pkg::SPFP_LVL_LOW;
		next_s.raw = cur;
		if (cur != s.raw)
			next_s.fcnt = 8'h00;
		else if (s.fcnt < 8'(spfp_pkg::FILT_CYC))
			next_s.fcnt = s.fcnt + 8'h01;
		else
			next_s.lvl = cur;
		// one event per excursion, judged at its return to low
		if (s.lvl == spfp_pkg::SPFP_LVL_HIGH)
		begin
			next_s.peak = spfp_pkg::SPFP_LVL_HIGH;
			if (s.hcnt != 16'hffff)
				next_s.hcnt = s.hcnt + 16'h0001;
			if (s.hcnt == 16'(spfp_pkg::BLOW_CYC))
				next_s.long_p = 1'b1;
		end
		else if (s.lvl == spfp_pkg::SPFP_LVL_MID)
		begin
			if (s.peak == spfp_pkg::SPFP_LVL_LOW)
				next_s.peak = spfp_pkg::SPFP_LVL_MID;
		end
		else
		begin
			next_s.hcnt = 16'h0000;
			next_s.peak = spfp_pkg::SPFP_LVL_LOW;
			next_s.mid_p = (s.peak == spfp_pkg::SPFP_LVL_MID);
			next_s.high_p = (s.peak == spfp_pkg::SPFP_LVL_HIGH);
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign ev.mid_pulse = s.mid_p;
	assign ev.high_pulse = s.high_p;
	assign ev.high_long = s.long_p;
	assign ev.high_now = (s.lvl == spfp_pkg::SPFP_LVL_HIGH);

	// a mid pulse is only reported once the supply is back low
	one_event_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.mid_p |-> !s.high_p && s.lvl == spfp_pkg::SPFP_LVL_LOW)
		else $error("mid and high events together");
endmodule // spfp_level_det

// ---- hdl/spfp_programmer.sv ----
// Notes on behaviour
// - one blow pulse sets one bit
// - long high pulse blows addressed bit
// - blown bits survive supply cycling
// - more bits blowable until lock; union
// - lock fuse refuses all programming
// - try mode high pulses loop states
// - try mode is mode key two
// - mid pulse increments code, saturating
// - addressed code stays applied afterwards
// - try extra high returns to parameter select
// - try allows unlimited readdressing
// - try mode never blows fuses
// - trial values clear on supply cycle
// - blow mode is mode key one
// - blow mode one parameter per cycle
// - no decrement; only supply cycle lowers
// - unblown parameters still tryable
// - duty parameter has eight-bit code
// - code increments on mid pulse fall
// - key counts mids between two highs
// - lock code 512 enables lock blow
module spfp_programmer
(
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        above_mid_i,
	input  wire logic        above_high_i,
	input  wire logic [39:0] fuse_init_i,
	output logic      [9:0]  sens_code_o,
	output logic      [9:0]  qdc_code_o,
	output logic      [9:0]  freq_code_o,
	output logic             locked_o,
	output logic             blowing_o
);
	// ==========================================
	// supply pulse detection
	spfp_pulse_if ev ();
	logic [39:0] fuse;

	spfp_level_det u_det
	(
		.clk_sys_i    (clk_sys_i),
		.reset_n_i    (reset_n_i),
		.above_mid_i  (above_mid_i),
		.above_high_i (above_high_i),
		.ev           (ev.src)
	);

	// ==========================================
	// state
	typedef struct packed {
		spfp_pkg::spfp_st_t st;
		logic               try_mode;
		logic [3:0]         key;
		logic [1:0]         sel;
		logic [9:0]         code;
		logic [3:0][9:0]    trial;
		logic               blow;
		logic [9:0]         blow_bit;
		logic               fired;
		logic               init;
		logic               sensed;
		logic [9:0]         sens_q;
		logic [9:0]         qdc_q;
		logic [9:0]         freq_q;
		logic               lock_q;
		logic               blowing_q;
	} spfp_st_all_t;

	spfp_st_all_t s, next_s;

	// map a register key to a slot, 2'h3 being the lock register
	function automatic logic [2:0] key_slot(input logic [3:0] k);
		unique case (k)
			spfp_pkg::KEY_SENS: key_slot = 3'h4;
			spfp_pkg::KEY_QDC:  key_slot = 3'h5;
			spfp_pkg::KEY_FREQ: key_slot = 3'h6;
			spfp_pkg::KEY_LOCK: key_slot = 3'h7;
			default:            key_slot = 3'h0;
		endcase
	endfunction

	function automatic logic [9:0] slot_max(input logic [1:0] sl);
		unique case (sl)
			2'h0: slot_max = spfp_pkg::MAX_SENS;
			2'h1: slot_max = spfp_pkg::MAX_QDC;
			2'h2: slot_max = spfp_pkg::MAX_FREQ;
			2'h3: slot_max = spfp_pkg::MAX_LOCK;
		endcase
	endfunction

	// a code is blowable only if it differs from the fuse value in exactly one bit
	function automatic logic one_hot(input logic [9:0] v);
		one_hot = (v != 10'h000) && ((v & (v - 10'h001)) == 10'h000);
	endfunction

	logic       locked;
	logic [2:0] ks;

	assign locked = fuse[39]; // lock fuse is bit 9 of the lock slot

	// ==========================================
	// programming state machine
	always_comb
	begin
		next_s = s;
		next_s.blow = 1'b0;
		ks = key_slot(s.key);
		// the bank senses its fuses on the first edge, so the trial codes
		// copy them one edge later; earlier they would start from zero
		if (!s.init)
		begin
			next_s.sensed = 1'b1;
			next_s.init = s.sensed;
			next_s.trial = fuse;
			next_s.st = spfp_pkg::SPFP_ST_MODE;
		end
		else if (!locked)
		begin
			unique case (s.st)
				spfp_pkg::SPFP_ST_MODE:
					if (ev.high_pulse)
					begin
						next_s.st = spfp_pkg::SPFP_ST_MODEKEY;
						next_s.key = 4'h0;
					end
				spfp_pkg::SPFP_ST_MODEKEY:
					if (ev.mid_pulse && s.key != 4'hf)
						next_s.key = s.key + 4'h1;
					else if (ev.high_pulse)
					begin
						if (s.key == spfp_pkg::KEY_TRY || s.key == spfp_pkg::KEY_BLOW)
						begin
							next_s.try_mode = (s.key == spfp_pkg::KEY_TRY);
							next_s.st = spfp_pkg::SPFP_ST_REGKEY;
						end
						else
							next_s.st = spfp_pkg::SPFP_ST_MODEKEY;
						next_s.key = 4'h0;
					end
				spfp_pkg::SPFP_ST_REG:
					if (ev.high_pulse)
					begin
						next_s.st = spfp_pkg::SPFP_ST_REGKEY;
						next_s.key = 4'h0;
					end
				spfp_pkg::SPFP_ST_REGKEY:
					if (ev.mid_pulse && s.key != 4'hf)
						next_s.key = s.key + 4'h1;
					else if (ev.high_pulse)
					begin
						if (ks[2])
						begin
							next_s.sel = ks[1:0];
							next_s.code = s.trial[ks[1:0]];
							next_s.st = spfp_pkg::SPFP_ST_ADDR;
						end
						else
							next_s.key = 4'h0;
					end
				spfp_pkg::SPFP_ST_ADDR:
					if (ev.mid_pulse)
					begin
						// saturate, never decrement
						if (s.code != slot_max(s.sel))
							next_s.code = s.code + 10'h001;
						next_s.trial[s.sel] = (s.code != slot_max(s.sel)) ?
							s.code + 10'h001 : s.code;
					end
					else if (ev.high_long && !s.try_mode && !s.fired)
					begin
						// only a lone bit above the fuse value is blown
						if (one_hot(s.code ^ fuse[s.sel*10 +: 10]) &&
							(s.sel != 2'h3 || s.code == spfp_pkg::LOCK_CODE))
						begin
							next_s.blow = 1'b1;
							next_s.blow_bit = s.code ^ fuse[s.sel*10 +: 10];
							next_s.fired = 1'b1;
						end
					end
					else if (ev.high_pulse)
					begin
						if (s.try_mode)
						begin
							next_s.st = spfp_pkg::SPFP_ST_REGKEY;
							next_s.key = 4'h0;
						end
						else
							next_s.st = spfp_pkg::SPFP_ST_DONE;
					end
				spfp_pkg::SPFP_ST_DONE:
					next_s.st = spfp_pkg::SPFP_ST_DONE;
			endcase
		end
		// code outputs show trial codes merged with blown fuses; the lock output shows the lock fuse only
		next_s.sens_q = s.trial[0] | fuse[9:0];
		next_s.qdc_q = s.trial[1] | fuse[19:10];
		next_s.freq_q = s.trial[2] | fuse[29:20];
		next_s.lock_q = locked;
		next_s.blowing_q = s.blow;
	end

	// a supply cycle is a reset, which is what drops trial values
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	spfp_fuse_bank #(.N(4)) u_fuse
	(
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.blow_i      (s.blow),
		.reg_i       (s.sel),
		.bit_i       (s.blow_bit),
		.fuse_init_i (fuse_init_i),
		.fuse_o      (fuse)
	);

	assign sens_code_o = s.sens_q;
	assign qdc_code_o = s.qdc_q;
	assign freq_code_o = s.freq_q;
	assign locked_o = s.lock_q;
	assign blowing_o = s.blowing_q;

	// ==========================================
	// checks
	sequence blow_req_s;
		s.blow && s.init;
	endsequence

	sequence fuse_set_s;
		(fuse[s.sel*10 +: 10] & s.blow_bit) == s.blow_bit;
	endsequence

	blow_takes_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		blow_req_s |=> fuse_set_s)
		else $error("blow did not set fuse");

	one_bit_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.blow |-> one_hot(s.blow_bit))
		else $error("blow of more than one bit");

	try_noblow_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.try_mode && s.st == spfp_pkg::SPFP_ST_ADDR |=> !s.blow)
		else $error("blow in try mode");

	lock_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init && locked |=> !s.blow && $stable(s.trial))
		else $error("programming after lock");

	code_step_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init && !locked && s.st == spfp_pkg::SPFP_ST_ADDR && ev.mid_pulse
		|=> s.code == $past(s.code) + 10'h001 ||
			s.code == slot_max(s.sel))
		else $error("code did not step");

	no_decr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.st == spfp_pkg::SPFP_ST_ADDR |=> s.code >= $past(s.code) ||
			s.st != spfp_pkg::SPFP_ST_ADDR)
		else $error("code decreased");

	blow_once_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.st == spfp_pkg::SPFP_ST_DONE |=> s.st == spfp_pkg::SPFP_ST_DONE)
		else $error("blow mode left parameter");

	lock_code_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.blow && s.sel == 2'h3 |-> s.code == spfp_pkg::LOCK_CODE)
		else $error("lock blown without code 512");

	out_merge_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init ##1 s.init |-> (sens_code_o & $past(fuse[9:0])) ==
			$past(fuse[9:0]))
		else $error("blown bit missing from output");

	// the trial codes pick up the sensed fuses once the bank has them
	init_copy_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!s.init && s.sensed |=> s.trial == $past(fuse))
		else $error("trial codes not loaded from fuses");

	try_loop_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init && !locked && s.try_mode && s.st == spfp_pkg::SPFP_ST_ADDR &&
		ev.high_pulse |=> s.st == spfp_pkg::SPFP_ST_REGKEY)
		else $error("try mode did not return to selection");

	blow_end_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init && !locked && !s.try_mode && s.st == spfp_pkg::SPFP_ST_ADDR &&
		ev.high_pulse |=> s.st == spfp_pkg::SPFP_ST_DONE)
		else $error("blow mode offered a second parameter");

	lock_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.init && locked |=> $stable(s.st) && $stable(s.code))
		else $error("selection moved after lock");

	blow_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.blow |=> blowing_o)
		else $error("blow strobe missing");

	// the level filter keeps the high level for a while after any drop
	blow_high_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s.blow |-> ev.high_now)
		else $error("blow outside a high pulse");
endmodule // spfp_programmer

// ---- include/spfp_pkg.sv ----
package spfp_pkg;
	// mode and register keys
	localparam logic [3:0] KEY_BLOW  = 4'h1;
	localparam logic [3:0] KEY_TRY   = 4'h2;
	localparam logic [3:0] KEY_SENS  = 4'h1;
	localparam logic [3:0] KEY_QDC   = 4'h2;
	localparam logic [3:0] KEY_FREQ  = 4'h3;
	localparam logic [3:0] KEY_LOCK  = 4'h6;
	// field widths and code limits
	localparam int CODE_W            = 10;
	localparam logic [9:0] MAX_SENS  = 10'h1ff;
	localparam logic [9:0] MAX_QDC   = 10'h0ff;
	localparam logic [9:0] MAX_FREQ  = 10'h01f;
	localparam logic [9:0] MAX_LOCK  = 10'h200;
	localparam logic [9:0] LOCK_CODE = 10'h200;
	localparam logic [9:0] CODE_RST  = 10'h000;
	// timing
	localparam int CLK_MHZ           = 25;
	localparam int FILT_NS           = 1000;
	localparam int FILT_CYC          = (FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int BLOW_US           = 40;
	localparam int BLOW_CYC          = BLOW_US * CLK_MHZ;
	// supply levels
	typedef enum logic [1:0] {
		SPFP_LVL_LOW,
		SPFP_LVL_MID,
		SPFP_LVL_HIGH
	} spfp_lvl_t;
	// programming states
	typedef enum logic [2:0] {
		SPFP_ST_MODE,
		SPFP_ST_MODEKEY,
		SPFP_ST_REG,
		SPFP_ST_REGKEY,
		SPFP_ST_ADDR,
		SPFP_ST_DONE
	} spfp_st_t;
endpackage

// ---- include/spfp_pulse_if.sv ----
interface spfp_pulse_if;
	logic mid_pulse;
	logic high_pulse;
	logic high_long;
	logic high_now;
	modport src
	(
		output mid_pulse,
		output high_pulse,
		output high_long,
		output high_now
	);
	modport dst
	(
		input  mid_pulse,
		input  high_pulse,
		input  high_long,
		input  high_now
	);
endinterface

// ---- tb/spfp_supply_model.sv ----
module spfp_supply_model
(
	input  wire logic clk_sys_i,
	output logic      above_mid_o,
	output logic      above_high_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		above_mid_o = 1'b0;
		above_high_o = 1'b0;
	end

	// =========================================
	// supply levels, changed off the sampling edge
	task automatic drive(input int lvl, input int n);
		@(negedge clk_sys_i);
		above_mid_o = (lvl > 0);
		above_high_o = (lvl > 1);
		repeat (n - 1) @(negedge clk_sys_i);
	endtask

	// a blow needs the long low gap before power may drop
	task automatic pulse(input int lvl, input int n);
		drive(lvl, n);
		drive(0, (n > 999) ? 1000 : 34);
	endtask

	// key train: optional leading high, n mids, closing high
	task automatic sel(input bit lead, input int n);
		if (lead)
		begin
			pulse(2, 30);
		end
		repeat (n) pulse(1, 30);
		pulse(2, 30);
	endtask

	// code steps up from its current trial value, one mid per step
	task automatic mids(input int n);
		repeat (n) pulse(1, 30);
	endtask
endmodule // spfp_supply_model

// ---- tb/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys_i;
	logic        reset_n_i;
	logic        above_mid_i;
	logic        above_high_i;
	logic        locked_o;
	logic        blowing_o;
	logic [9:0]  sens_code_o;
	logic [9:0]  qdc_code_o;
	logic [9:0]  freq_code_o;
	logic [39:0] fuse_init_i;
	int          err_total;
	int          tests_run;
	int          seed;
	int          nblow;
	int          eblow;
	int          trial[4];
	int          fz[4];
	int          mx[4] = '{511, 255, 31, 512};
	int          steps[3] = '{4, 1, 3};

	spfp_supply_model sup
	(
		.clk_sys_i   (clk_sys_i),
		.above_mid_o (above_mid_i),
		.above_high_o(above_high_i)
	);

	spfp_programmer dut
	(
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.above_mid_i (above_mid_i),
		.above_high_i(above_high_i),
		.fuse_init_i (fuse_init_i),
		.sens_code_o (sens_code_o),
		.qdc_code_o  (qdc_code_o),
		.freq_code_o (freq_code_o),
		.locked_o    (locked_o),
		.blowing_o   (blowing_o)
	);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// count blow strobes; each stands one cycle only
	always @(negedge clk_sys_i)
	begin
		if (blowing_o === 1'b1)
		begin
			nblow++;
		end
	end

	// =========================================
	// comparison and model helpers
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic check_all();
		repeat (4) @(negedge clk_sys_i);
		chk(sens_code_o, 10'(trial[0] | fz[0]));
		chk(qdc_code_o, 10'(trial[1] | fz[1]));
		chk(freq_code_o, 10'(trial[2] | fz[2]));
		chk({9'h000, locked_o}, 10'(fz[3] >> 9));
		chk(10'(nblow), 10'(eblow));
	endtask

	// supply off: fuses kept outside, unblown bits drop back
	task automatic power();
		@(negedge clk_sys_i);
		reset_n_i = 1'b0;
		fuse_init_i = {10'(fz[3]), 10'(fz[2]), 10'(fz[1]), 10'(fz[0])};
		repeat (5) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		trial = fz;
		repeat (6) @(negedge clk_sys_i);
	endtask

	task automatic addr(input int r, input int n);
		sup.mids(n);
		trial[r] = (trial[r] + n > mx[r]) ? mx[r] : trial[r] + n;
	endtask

	// only a single differing bit may be blown
	task automatic blow(input int r);
		sup.pulse(2, 1100);
		if ($countones(trial[r] ^ fz[r]) == 1)
		begin
			fz[r] = fz[r] | trial[r];
			eblow++;
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && tests_run > 0)
		begin
			$display("Test passed");
		end
		else
		begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge clk_sys_i);
		err_total++;
		stop_test();
	end

	// =========================================
	// main sequence
	initial
	begin
		seed = 45;
		reset_n_i = 1'b0;
		fuse_init_i = '0;
		repeat (20) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		check_all();
		sup.sel(1, 2);
		sup.sel(0, 1);
		addr(0, ($random(seed) & 7) + 1);
		check_all();
		sup.sel(1, 3);
		addr(2, 33);
		check_all();
		sup.sel(1, 2);
		addr(1, 258);
		check_all();
		sup.sel(1, 1);
		addr(0, 2);
		check_all();
		sup.pulse(2, 1100);
		check_all();
		power();
		check_all();
		// bit 2, then bit 0, then a refused multi-bit code
		foreach (steps[i])
		begin
			sup.sel(1, 1);
			sup.sel(0, 2);
			addr(1, steps[i]);
			blow(1);
			check_all();
			sup.sel(1, 2);
			sup.mids(2);
			check_all();
			power();
			check_all();
		end
		sup.sel(1, 2);
		sup.sel(0, 3);
		addr(2, 5);
		check_all();
		power();
		sup.sel(1, 1);
		sup.sel(0, 6);
		addr(3, 513);
		blow(3);
		power();
		check_all();
		sup.sel(1, 2);
		sup.sel(0, 1);
		sup.mids(3);
		check_all();
		stop_test();
	end
endmodule // tb
